// ### verilog/lpfa_consts.vh
`ifndef LPFA_CONSTS_VH
`define LPFA_CONSTS_VH
// ****************************************
// word layout and packet codes
// ****************************************
`define LPFA_WORD_W 32
`define LPFA_HDR_LOCAL 32'h0000_0002
`define LPFA_HDR_FWD 32'h0000_0005
`define LPFA_OP_WRITE 32'h0000_0000
`define LPFA_OP_READ 32'h8000_0000
`define LPFA_ADDR_W 32
`define LPFA_CNT_RST 32'h0000_0000
`endif

// ### verilog/lpfa_fwd.v
`timescale 1ns/1ps
`include "lpfa_consts.vh"
// ****************************************
// forwarding stage: registered word pass with back-pressure
// ****************************************
module lpfa_fwd (
	input wire sys_clk_in,
	input wire rst_b_in,
	input wire src_valid_in,
	input wire [31:0] src_data_in,
	input wire src_last_in,
	output wire src_ready_out,
	output reg dst_valid_ff,
	output reg [31:0] dst_data_ff,
	output reg dst_last_ff,
	input wire dst_ready_in
);
	// one slot; refills in the cycle it empties
	assign src_ready_out = !dst_valid_ff || dst_ready_in;

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			dst_valid_ff <= 1'b0;
			dst_data_ff <= 32'h0000_0000;
			dst_last_ff <= 1'b0;
		end else if (src_ready_out) begin
			dst_valid_ff <= src_valid_in;
			dst_data_ff <= src_data_in;
			dst_last_ff <= src_last_in;
		end
	end
endmodule

// ### verilog/lpfa_merge.v
`timescale 1ns/1ps
`include "lpfa_consts.vh"
// ****************************************
// upstream merge: local read data versus returning downstream traffic
// ****************************************
module lpfa_merge (
	input wire sys_clk_in,
	input wire rst_b_in,
	input wire loc_valid_in,
	input wire [31:0] loc_data_in,
	input wire loc_last_in,
	output wire loc_ready_out,
	input wire ret_valid_in,
	input wire [31:0] ret_data_in,
	input wire ret_last_in,
	output wire ret_ready_out,
	output reg up_valid_ff,
	output reg [31:0] up_data_ff,
	output reg up_last_ff,
	input wire up_ready_in
);
	// packets never interleave: owner held until last word
	reg own_ret_ff;
	reg busy_ff;
	wire slot;
	wire pick_ret;
	assign slot = !up_valid_ff || up_ready_in;
	assign pick_ret = busy_ff ? own_ret_ff : (ret_valid_in && !loc_valid_in ? 1'b1 : 1'b0);
	assign loc_ready_out = slot && !pick_ret;
	assign ret_ready_out = slot && pick_ret;

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			up_valid_ff <= 1'b0;
			up_data_ff <= 32'h0000_0000;
			up_last_ff <= 1'b0;
			own_ret_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (slot) begin
			up_valid_ff <= pick_ret ? ret_valid_in : loc_valid_in;
			up_data_ff <= pick_ret ? ret_data_in : loc_data_in;
			up_last_ff <= pick_ret ? ret_last_in : loc_last_in;
			if (pick_ret ? ret_valid_in : loc_valid_in) begin
				own_ret_ff <= pick_ret;
				busy_ff <= !(pick_ret ? ret_last_in : loc_last_in);
			end
		end
	end
endmodule

// ### verilog/lpfa_top.v
`timescale 1ns/1ps
`include "lpfa_consts.vh"
module lpfa_top #(
	parameter WORD_W = `LPFA_WORD_W,
	parameter ADDR_W = `LPFA_ADDR_W
) (
	input wire sys_clk_in,
	input wire rst_b_in,
	// upstream command input
	input wire up_rx_valid_in,
	input wire [WORD_W-1:0] up_rx_data_in,
	input wire up_rx_last_in,
	output reg up_rx_ready_ff_out,
	// sidestream command input
	input wire side_rx_valid_in,
	input wire [WORD_W-1:0] side_rx_data_in,
	input wire side_rx_last_in,
	output reg side_rx_ready_ff_out,
	input wire side_sel_in,
	// upstream response output
	output wire up_tx_valid_out,
	output wire [WORD_W-1:0] up_tx_data_out,
	output wire up_tx_last_out,
	input wire up_tx_ready_in,
	// downstream command output
	output wire dn_tx_valid_out,
	output wire [WORD_W-1:0] dn_tx_data_out,
	output wire dn_tx_last_out,
	input wire dn_tx_ready_in,
	// downstream response input
	input wire dn_rx_valid_in,
	input wire [WORD_W-1:0] dn_rx_data_in,
	input wire dn_rx_last_in,
	output wire dn_rx_ready_out,
	// local function port
	output reg fn_wr_ff_out,
	output reg fn_rd_ff_out,
	output reg [ADDR_W-1:0] fn_addr_ff_out,
	output reg [WORD_W-1:0] fn_wdata_ff_out,
	input wire fn_rd_valid_in,
	input wire [WORD_W-1:0] fn_rdata_in
);
	// ****************************************
	// states
	// ****************************************
	localparam S_HDR = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_OP = 3'h2;
	localparam S_WR = 3'h3;
	localparam S_CNT = 3'h4;
	localparam S_RD = 3'h5;
	localparam S_FWD = 3'h6;
	localparam S_DROP = 3'h7;
	localparam [ADDR_W-1:0] ADDR_STEP = {{(ADDR_W-1){1'b0}}, 1'b1};
	localparam [WORD_W-1:0] CNT_ONE = {{(WORD_W-1){1'b0}}, 1'b1};

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [ADDR_W-1:0] addr_ff;
	reg [ADDR_W-1:0] nxt_addr;
	reg [WORD_W-1:0] rcnt_ff;
	reg [WORD_W-1:0] nxt_rcnt;
	reg rd_wait_ff;
	reg side_sel_s1_ff;
	reg side_sel_ff;

	// ****************************************
	// link selection
	// ****************************************
	// strap-like select, synchronised; swap only between packets
	reg sel_ff;
	wire rx_valid = sel_ff ? side_rx_valid_in : up_rx_valid_in;
	wire [WORD_W-1:0] rx_data = sel_ff ? side_rx_data_in : up_rx_data_in;
	wire rx_last = sel_ff ? side_rx_last_in : up_rx_last_in;
	// a word is taken when the chosen ready flop was high
	wire rdy_now = sel_ff ? side_rx_ready_ff_out : up_rx_ready_ff_out;
	wire take = rx_valid && rdy_now;
	// no swap while a header is taken, else the packet splits across links
	wire sel_nxt = (state_ff == S_HDR && !take) ? side_sel_ff : sel_ff;

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			side_sel_s1_ff <= 1'b0;
			side_sel_ff <= 1'b0;
			sel_ff <= 1'b0;
		end else begin
			side_sel_s1_ff <= side_sel_in;
			side_sel_ff <= side_sel_s1_ff;
			sel_ff <= sel_nxt;
		end
	end

	// ****************************************
	// forward and return paths
	// ****************************************
	wire fwd_ready;
	wire loc_ready;
	// one-slot stage: promise a word only when the slot is sure to be free
	wire fwd_room = fwd_ready && !(take && state_ff == S_FWD);
	reg loc_valid_ff;
	reg [WORD_W-1:0] loc_data_ff;
	reg loc_last_ff;

	lpfa_fwd u_fwd (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.src_valid_in(take && state_ff == S_FWD),
		.src_data_in(rx_data),
		.src_last_in(rx_last),
		.src_ready_out(fwd_ready),
		.dst_valid_ff(dn_tx_valid_out),
		.dst_data_ff(dn_tx_data_out),
		.dst_last_ff(dn_tx_last_out),
		.dst_ready_in(dn_tx_ready_in)
	);

	lpfa_merge u_merge (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.loc_valid_in(loc_valid_ff),
		.loc_data_in(loc_data_ff),
		.loc_last_in(loc_last_ff),
		.loc_ready_out(loc_ready),
		.ret_valid_in(dn_rx_valid_in),
		.ret_data_in(dn_rx_data_in),
		.ret_last_in(dn_rx_last_in),
		.ret_ready_out(dn_rx_ready_out),
		.up_valid_ff(up_tx_valid_out),
		.up_data_ff(up_tx_data_out),
		.up_last_ff(up_tx_last_out),
		.up_ready_in(up_tx_ready_in)
	);

	// ****************************************
	// packet decoder
	// ****************************************
	wire rd_busy = (state_ff == S_RD);

	always @* begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_rcnt = rcnt_ff;
		case (state_ff)
			S_HDR: begin
				if (take) begin
					if (rx_data == `LPFA_HDR_LOCAL)
						nxt_state = rx_last ? S_HDR : S_ADDR;
					else if (rx_data == `LPFA_HDR_FWD)
						nxt_state = rx_last ? S_HDR : S_FWD;
					else
						nxt_state = rx_last ? S_HDR : S_DROP;
				end
			end
			S_ADDR: begin
				if (take) begin
					nxt_addr = rx_data[ADDR_W-1:0];
					nxt_state = rx_last ? S_HDR : S_OP;
				end
			end
			S_OP: begin
				if (take) begin
					if (rx_data == `LPFA_OP_WRITE)
						nxt_state = rx_last ? S_HDR : S_WR;
					else if (rx_data == `LPFA_OP_READ)
						nxt_state = rx_last ? S_HDR : S_CNT;
					else
						nxt_state = rx_last ? S_HDR : S_DROP;
				end
			end
			S_WR: begin
				if (take) begin
					nxt_addr = addr_ff + ADDR_STEP;
					if (rx_last)
						nxt_state = S_HDR;
				end
			end
			S_CNT: begin
				if (take) begin
					nxt_rcnt = rx_data;
					nxt_state = (rx_data == `LPFA_CNT_RST) ? S_HDR : S_RD;
				end
			end
			S_RD: begin
				// one fetch in flight at a time; returned word stalls on upstream
				if (fn_rd_valid_in && !loc_valid_ff) begin
					nxt_addr = addr_ff + ADDR_STEP;
					nxt_rcnt = rcnt_ff - CNT_ONE;
					if (rcnt_ff == CNT_ONE)
						nxt_state = S_HDR;
				end
			end
			S_FWD: begin
				if (take && rx_last)
					nxt_state = S_HDR;
			end
			S_DROP: begin
				if (take && rx_last)
					nxt_state = S_HDR;
			end
			default: nxt_state = S_HDR;
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_ff <= S_HDR;
			addr_ff <= {ADDR_W{1'b0}};
			rcnt_ff <= `LPFA_CNT_RST;
			rd_wait_ff <= 1'b0;
			up_rx_ready_ff_out <= 1'b0;
			side_rx_ready_ff_out <= 1'b0;
			fn_wr_ff_out <= 1'b0;
			fn_rd_ff_out <= 1'b0;
			fn_addr_ff_out <= {ADDR_W{1'b0}};
			fn_wdata_ff_out <= {WORD_W{1'b0}};
			loc_valid_ff <= 1'b0;
			loc_data_ff <= {WORD_W{1'b0}};
			loc_last_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			rcnt_ff <= nxt_rcnt;
			// accept one word per cycle until a last word or a state change, then drop for a cycle; hold off while reading or forward slot full
			up_rx_ready_ff_out <= !sel_nxt && nxt_state != S_RD && !(take && (rx_last || nxt_state != state_ff))
				&& (nxt_state != S_FWD || fwd_room);
			side_rx_ready_ff_out <= sel_nxt && nxt_state != S_RD && !(take && (rx_last || nxt_state != state_ff))
				&& (nxt_state != S_FWD || fwd_room);
			fn_wr_ff_out <= (state_ff == S_WR) && take;
			fn_wdata_ff_out <= rx_data;
			// one fetch in flight: a second pulse before the answer would reread the same address
			fn_rd_ff_out <= rd_busy && !fn_rd_ff_out && !rd_wait_ff && !loc_valid_ff;
			if (fn_rd_ff_out)
				rd_wait_ff <= 1'b1;
			else if (fn_rd_valid_in)
				rd_wait_ff <= 1'b0;
			if (state_ff == S_WR || rd_busy)
				fn_addr_ff_out <= addr_ff;
			if (loc_valid_ff && loc_ready)
				loc_valid_ff <= 1'b0;
			if (rd_busy && fn_rd_valid_in && !loc_valid_ff) begin
				loc_valid_ff <= 1'b1;
				loc_data_ff <= fn_rdata_in;
				loc_last_ff <= (rcnt_ff == CNT_ONE);
			end
		end
	end
endmodule

// ### verification/lpfa_fn_mem.sv
`timescale 1ns/1ps
// ****
// function space behind the local port
// ****
module lpfa_fn_mem (
	input wire sys_clk_in,
	input wire rst_b_in,
	input wire wr_in,
	input wire rd_in,
	input wire [31:0] addr_in,
	input wire [31:0] wdata_in,
	output wire rd_valid_out,
	output wire [31:0] rdata_out
);
	reg [31:0] mem [0:15];
	reg [1:0] pipe_ff;
	reg [31:0] d1_ff, rdata_ff;
	assign rd_valid_out = pipe_ff[1];
	assign rdata_out = rdata_ff;
	always @(posedge sys_clk_in) begin
		if (wr_in) mem[addr_in[3:0]] <= wdata_in;
		// idle data toggles so stale words never look valid
		d1_ff <= rd_in ? mem[addr_in[3:0]] : ~d1_ff;
		rdata_ff <= pipe_ff[0] ? d1_ff : ~rdata_ff;
		pipe_ff <= rst_b_in ? {pipe_ff[0], rd_in} : 2'h0;
	end
endmodule

// ### verification/lpfa_top_asserts.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module lpfa_top_asserts #(parameter WORD_W = 32, parameter ADDR_W = 32) (
	input wire sys_clk_in,
	input wire rst_b_in,
	input wire up_rx_valid_in,
	input wire [WORD_W-1:0] up_rx_data_in,
	input wire up_rx_last_in,
	input wire up_rx_ready_ff_out,
	input wire side_rx_valid_in,
	input wire [WORD_W-1:0] side_rx_data_in,
	input wire side_rx_ready_ff_out,
	input wire up_tx_valid_out,
	input wire [WORD_W-1:0] up_tx_data_out,
	input wire up_tx_ready_in,
	input wire dn_tx_valid_out,
	input wire [WORD_W-1:0] dn_tx_data_out,
	input wire dn_tx_ready_in,
	input wire dn_rx_valid_in,
	input wire dn_rx_last_in,
	input wire dn_rx_ready_out,
	input wire fn_wr_ff_out,
	input wire fn_rd_ff_out,
	input wire [ADDR_W-1:0] fn_addr_ff_out,
	input wire [WORD_W-1:0] fn_wdata_ff_out,
	input wire fn_rd_valid_in,
	input wire [WORD_W-1:0] fn_rdata_in
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// mirrors the merge lock: a paused downstream reply holds the upstream path
	reg ret_open_ff;
	always @(posedge sys_clk_in) begin
		if (!rst_b_in)
			ret_open_ff <= 1'b0;
		else if (dn_rx_valid_in && dn_rx_ready_out)
			ret_open_ff <= !dn_rx_last_in;
	end
	a_reset_quiet: assert property ($rose(rst_b_in) |-> !fn_wr_ff_out && !fn_rd_ff_out
		&& !up_tx_valid_out && !dn_tx_valid_out && !up_rx_ready_ff_out) else $error("busy out of reset");
	a_up_hold: assert property (up_tx_valid_out && !up_tx_ready_in |=> up_tx_valid_out
		&& $stable(up_tx_data_out)) else $error("upstream word dropped");
	a_dn_hold: assert property (dn_tx_valid_out && !dn_tx_ready_in |=> dn_tx_valid_out
		&& $stable(dn_tx_data_out)) else $error("downstream word dropped");
	a_wr_addr_step: assert property (fn_wr_ff_out && $past(fn_wr_ff_out)
		|-> fn_addr_ff_out == $past(fn_addr_ff_out) + 1) else $error("write address not stepped");
	a_rd_answer: assert property (fn_rd_valid_in && !up_tx_valid_out && !dn_rx_valid_in && !ret_open_ff
		|-> ##2 up_tx_valid_out && up_tx_data_out == $past(fn_rdata_in, 2)) else $error("read word not returned");
	a_wr_rd_excl: assert property (!(fn_wr_ff_out && fn_rd_ff_out)) else $error("write and read together");
	a_rdy_drop_last: assert property (up_rx_valid_in && up_rx_ready_ff_out && up_rx_last_in
		|=> !up_rx_ready_ff_out) else $error("ready held after last");
	a_wr_data_src: assert property (fn_wr_ff_out |-> ($past(up_rx_valid_in && up_rx_ready_ff_out)
		&& fn_wdata_ff_out == $past(up_rx_data_in)) || ($past(side_rx_valid_in && side_rx_ready_ff_out)
		&& fn_wdata_ff_out == $past(side_rx_data_in))) else $error("write data not from taken word");
endmodule
bind lpfa_top lpfa_top_asserts #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) i_lpfa_top_asserts (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .up_rx_valid_in(up_rx_valid_in),
	.up_rx_data_in(up_rx_data_in), .up_rx_last_in(up_rx_last_in), .up_rx_ready_ff_out(up_rx_ready_ff_out),
	.side_rx_valid_in(side_rx_valid_in), .side_rx_data_in(side_rx_data_in),
	.side_rx_ready_ff_out(side_rx_ready_ff_out), .up_tx_valid_out(up_tx_valid_out),
	.up_tx_data_out(up_tx_data_out), .up_tx_ready_in(up_tx_ready_in), .dn_tx_valid_out(dn_tx_valid_out),
	.dn_tx_data_out(dn_tx_data_out), .dn_tx_ready_in(dn_tx_ready_in), .fn_wr_ff_out(fn_wr_ff_out),
	.dn_rx_valid_in(dn_rx_valid_in), .dn_rx_last_in(dn_rx_last_in), .dn_rx_ready_out(dn_rx_ready_out),
	.fn_rd_ff_out(fn_rd_ff_out), .fn_addr_ff_out(fn_addr_ff_out), .fn_wdata_ff_out(fn_wdata_ff_out),
	.fn_rd_valid_in(fn_rd_valid_in), .fn_rdata_in(fn_rdata_in));

// ### verification/lpfa_top_tb.sv
`timescale 1ns/1ps
`include "lpfa_consts.vh"
module lpfa_top_tb;
	// ****
	// harness
	// ****
	reg clk = 0, rst_b = 0, rx_v = 0, rx_l = 0, sel = 0, up_r = 0, dn_r = 0;
	reg [1:0] tgt = 0;
	reg [31:0] rx_d = 0;
	wire up_rdy, sd_rdy, dn_rdy, utv, utl, dtv, dtl, wr, rd, rv;
	wire [31:0] utd, dtd, adr, wd, rdat;
	integer fail_count = 0, n_compared = 0, n_acc = 0, a;
	always #5 clk = ~clk;
	always @(posedge clk) if (wr || rd) n_acc <= n_acc + 1;
	lpfa_top i_lpfa_top (.sys_clk_in(clk), .rst_b_in(rst_b), .up_rx_valid_in(rx_v && tgt == 0),
		.up_rx_data_in(rx_d), .up_rx_last_in(rx_l), .up_rx_ready_ff_out(up_rdy),
		.side_rx_valid_in(rx_v && tgt == 1), .side_rx_data_in(rx_d), .side_rx_last_in(rx_l),
		.side_rx_ready_ff_out(sd_rdy), .side_sel_in(sel), .up_tx_valid_out(utv), .up_tx_data_out(utd),
		.up_tx_last_out(utl), .up_tx_ready_in(up_r), .dn_tx_valid_out(dtv), .dn_tx_data_out(dtd),
		.dn_tx_last_out(dtl), .dn_tx_ready_in(dn_r), .dn_rx_valid_in(rx_v && tgt == 2), .dn_rx_data_in(rx_d),
		.dn_rx_last_in(rx_l), .dn_rx_ready_out(dn_rdy), .fn_wr_ff_out(wr), .fn_rd_ff_out(rd),
		.fn_addr_ff_out(adr), .fn_wdata_ff_out(wd), .fn_rd_valid_in(rv), .fn_rdata_in(rdat));
	lpfa_fn_mem i_lpfa_fn_mem (.sys_clk_in(clk), .rst_b_in(rst_b), .wr_in(wr), .rd_in(rd), .addr_in(adr),
		.wdata_in(wd), .rd_valid_out(rv), .rdata_out(rdat));
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input [32:0] g, input [32:0] e);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task hang;
		begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: wait ran out", $time);
			summarize;
		end
	endtask
	// t: 0 upstream, 1 sidestream, 2 downstream return
	task send(input [1:0] t, input [31:0] w, input l);
		integer i;
		begin
			tgt <= t;
			rx_d <= w;
			rx_l <= l;
			rx_v <= 1'b1;
			for (i = 0; i < 60; i = i + 1) begin
				@(posedge clk);
				if ((t == 0 ? up_rdy : t == 1 ? sd_rdy : dn_rdy) === 1'b1) i = 99;
			end
			if (i != 100) hang;
			// one idle edge so valid is never set twice in a step
			if (l) begin
				rx_v <= 1'b0;
				@(posedge clk);
			end
		end
	endtask
	// ready toggles every edge to stall the design half the time
	task get(input s, input [31:0] w, input l);
		integer i;
		begin
			for (i = 0; i < 60; i = i + 1) begin
				@(posedge clk);
				if ((s ? dtv && dn_r : utv && up_r) === 1'b1) begin
					chk(s ? {dtl, dtd} : {utl, utd}, {l, w});
					i = 99;
				end
				if (s) dn_r <= ~dn_r;
				else up_r <= ~up_r;
			end
			if (i != 100) hang;
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_local;
		begin
			send(0, `LPFA_HDR_LOCAL, 0);
			send(0, 32'h10, 0);
			send(0, `LPFA_OP_WRITE, 0);
			send(0, 32'ha0, 0);
			send(0, 32'ha1, 0);
			send(0, 32'ha2, 1);
			send(0, `LPFA_HDR_LOCAL, 0);
			send(0, 32'h10, 0);
			send(0, `LPFA_OP_READ, 0);
			send(0, 32'h3, 1);
			get(0, 32'ha0, 0);
			get(0, 32'ha1, 0);
			get(0, 32'ha2, 1);
		end
	endtask
	task t_fwd;
		begin
			a = n_acc;
			fork
				begin
					send(0, `LPFA_HDR_FWD, 0);
					send(0, `LPFA_HDR_LOCAL, 0);
					send(0, 32'h6000, 0);
					send(0, `LPFA_OP_WRITE, 0);
					send(0, 32'h1, 1);
				end
				begin
					get(1, `LPFA_HDR_LOCAL, 0);
					get(1, 32'h6000, 0);
					get(1, `LPFA_OP_WRITE, 0);
					get(1, 32'h1, 1);
				end
			join
			chk(n_acc - a, 0);
		end
	endtask
	task t_ret;
		fork
			begin
				send(2, 32'hbeef_0001, 0);
				send(2, 32'hbeef_0002, 1);
			end
			begin
				get(0, 32'hbeef_0001, 0);
				get(0, 32'hbeef_0002, 1);
			end
		join
	endtask
	task t_bad;
		begin
			a = n_acc;
			send(0, 32'h7, 0);
			send(0, 32'h12, 1);
			send(0, `LPFA_HDR_LOCAL, 0);
			send(0, 32'h10, 0);
			send(0, 32'h3, 0);
			send(0, 32'h55, 1);
			repeat (5) @(posedge clk);
			chk(n_acc - a, 0);
			chk({dtv, utv}, 0);
		end
	endtask
	task t_side;
		begin
			sel <= 1'b1;
			repeat (6) @(posedge clk);
			chk(up_rdy, 1'b0);
			send(1, `LPFA_HDR_LOCAL, 0);
			send(1, 32'h15, 0);
			send(1, `LPFA_OP_WRITE, 0);
			send(1, 32'hc5, 1);
			send(1, `LPFA_HDR_LOCAL, 0);
			send(1, 32'h15, 0);
			send(1, `LPFA_OP_READ, 0);
			send(1, 32'h1, 1);
			get(0, 32'hc5, 1);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_local;
		t_fwd;
		t_ret;
		t_bad;
		t_side;
		summarize;
	end
endmodule
